// file: anc_source.sv
// behavioural decoder core that loads one ancillary block into the bank
module anc_source #(
  parameter int GAP = 0
) (
  input  wire logic  clk_in,
  input  wire logic  go_in,
  output logic       load_out = 1'b0,
  output logic [5:0] index_out = 6'h00,
  output logic [7:0] data_out = 8'h00,
  output logic       done_out = 1'b0,
  output logic [15:0] count_out = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // 56 bytes, each followed by GAP idle cycles, then done with the bit count
  always @(posedge go_in) begin
    for (int i = 0; i < 56; i++) begin
      @(negedge clk_in);
      load_out = 1'b1;
      index_out = 6'(i);
      data_out = 8'(i) ^ 8'ha5;
      repeat (GAP) begin
        @(negedge clk_in);
        load_out = 1'b0;
        data_out = ~data_out;
      end
    end
    @(negedge clk_in);
    load_out = 1'b0;
    done_out = 1'b1;
    count_out = 16'h01c0;
    @(negedge clk_in);
    done_out = 1'b0;
    count_out = ~count_out;
  end
endmodule

// file: decoder_tone_ancillary_regs.sv
// host-visible tone control, run and ancillary data registers of the audio decoder
`include "tone_anc_regs.svh"

module decoder_tone_ancillary_regs #(
  parameter logic [7:0] FIRMWARE_CODE = 8'h5a, // arbitrary value
  parameter int         ANC_BYTES     = `ANC_BUFFER_BYTES
) (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  soft_reset_in,
  input  wire logic                  boot_done_in,
  // host register port
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  output logic      [7:0]            reg_rdata_out,
  // ancillary data loader from the decoder core
  input  wire logic                  anc_load_in,
  input  wire logic [5:0]            anc_load_index_in,
  input  wire logic [7:0]            anc_load_data_in,
  input  wire logic                  anc_block_done_in,
  input  wire logic [15:0]           anc_bit_count_in,
  // settings handed to the decoder core
  output logic                       decode_run_out,
  output logic      [15:0]           treble_corner_value_out,
  output logic      [15:0]           bass_corner_value_out,
  output logic signed [7:0]          treble_gain_out,
  output logic signed [7:0]          bass_gain_out,
  output logic      [7:0]            tone_headroom_out,
  output logic      [7:0]            ancillary_bit_count_low_out,
  output logic      [7:0]            ancillary_bit_count_high_out
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_sync;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // register state
  // ****************************************
  tone_anc_pkg::decode_state_t state;
  tone_anc_pkg::decode_state_t next_state;
  tone_anc_pkg::reg_byte_t     treble_low;
  tone_anc_pkg::reg_byte_t     treble_high;
  tone_anc_pkg::reg_byte_t     bass_low;
  tone_anc_pkg::reg_byte_t     bass_high;
  tone_anc_pkg::reg_byte_t     next_treble_low;
  tone_anc_pkg::reg_byte_t     next_treble_high;
  tone_anc_pkg::reg_byte_t     next_bass_low;
  tone_anc_pkg::reg_byte_t     next_bass_high;
  logic [1:0]                  treble_written;
  logic [1:0]                  bass_written;
  logic [1:0]                  next_treble_written;
  logic [1:0]                  next_bass_written;
  logic [15:0]                 treble_applied;
  logic [15:0]                 bass_applied;
  logic [15:0]                 next_treble_applied;
  logic [15:0]                 next_bass_applied;
  tone_anc_pkg::reg_byte_t     treble_gain;
  tone_anc_pkg::reg_byte_t     bass_gain;
  tone_anc_pkg::reg_byte_t     headroom;
  tone_anc_pkg::reg_byte_t     next_treble_gain;
  tone_anc_pkg::reg_byte_t     next_bass_gain;
  tone_anc_pkg::reg_byte_t     next_headroom;
  logic                        anc_ready;
  logic                        next_anc_ready;
  logic [15:0]                 anc_count;
  logic [15:0]                 next_anc_count;
  tone_anc_pkg::reg_byte_t     anc_mem [ANC_BYTES];
  logic [7:0]                  rdata;
  logic [7:0]                  next_rdata;
  logic                        clear_all;

  // both reset sources zero the bank, soft reset all of it but the read data register rdata
  assign clear_all = soft_reset_in;

  // next values of control registers and run state
  always_comb begin
    next_state          = state;
    next_treble_low     = treble_low;
    next_treble_high    = treble_high;
    next_bass_low       = bass_low;
    next_bass_high      = bass_high;
    next_treble_written = treble_written;
    next_bass_written   = bass_written;
    next_treble_applied = treble_applied;
    next_bass_applied   = bass_applied;
    next_treble_gain    = treble_gain;
    next_bass_gain      = bass_gain;
    next_headroom       = headroom;
    next_anc_ready      = anc_ready;
    next_anc_count      = anc_count;
    if (reg_write_in) begin
      if (reg_addr_in == `DECODE_RUN_CONTROL_OFS) begin
        // bit 0 leaves idle and starts decoding
        next_state = reg_wdata_in[`RUN_BIT] ? tone_anc_pkg::DECODE_RUNNING
                                            : tone_anc_pkg::DECODE_IDLE;
      end else if (reg_addr_in == `TREBLE_CORNER_LOW_OFS) begin
        next_treble_low      = reg_wdata_in;
        next_treble_written[0] = 1'b1;
      end else if (reg_addr_in == `TREBLE_CORNER_HIGH_OFS) begin
        next_treble_high     = reg_wdata_in;
        next_treble_written[1] = 1'b1;
      end else if (reg_addr_in == `BASS_CORNER_LOW_OFS) begin
        next_bass_low        = reg_wdata_in;
        next_bass_written[0] = 1'b1;
      end else if (reg_addr_in == `BASS_CORNER_HIGH_OFS) begin
        next_bass_high       = reg_wdata_in;
        next_bass_written[1] = 1'b1;
      end else if (reg_addr_in == `TREBLE_GAIN_OFS) begin
        next_treble_gain = reg_wdata_in;
      end else if (reg_addr_in == `BASS_GAIN_OFS) begin
        next_bass_gain = reg_wdata_in;
      end else if (reg_addr_in == `TONE_HEADROOM_OFS) begin
        next_headroom = reg_wdata_in;
      end else if (reg_addr_in == `ANC_READY_STATUS_OFS) begin
        // writing zero clears the flag, writing one is ignored
        if (!reg_wdata_in[`ANC_READY_BIT]) begin
          next_anc_ready = 1'b0;
        end
      end
    end
    // corners move to the filter only once both bytes are in
    if (next_treble_written == 2'b11) begin
      next_treble_applied = {next_treble_high, next_treble_low};
      next_treble_written = 2'b00;
    end
    if (next_bass_written == 2'b11) begin
      next_bass_applied = {next_bass_high, next_bass_low};
      next_bass_written = 2'b00;
    end
    // block completion sets the flag, winning over a clear
    if (anc_block_done_in) begin
      next_anc_ready = 1'b1;
      next_anc_count = anc_bit_count_in;
    end
  end

  // register the control state
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state          <= tone_anc_pkg::DECODE_IDLE;
      treble_low     <= `REG_RESET_VALUE;
      treble_high    <= `REG_RESET_VALUE;
      bass_low       <= `REG_RESET_VALUE;
      bass_high      <= `REG_RESET_VALUE;
      treble_written <= 2'b00;
      bass_written   <= 2'b00;
      treble_applied <= 16'h0000;
      bass_applied   <= 16'h0000;
      treble_gain    <= `REG_RESET_VALUE;
      bass_gain      <= `REG_RESET_VALUE;
      headroom       <= `REG_RESET_VALUE;
      anc_ready      <= 1'b0;
      anc_count      <= 16'h0000;
    end else if (clear_all) begin
      state          <= tone_anc_pkg::DECODE_IDLE;
      treble_low     <= `REG_RESET_VALUE;
      treble_high    <= `REG_RESET_VALUE;
      bass_low       <= `REG_RESET_VALUE;
      bass_high      <= `REG_RESET_VALUE;
      treble_written <= 2'b00;
      bass_written   <= 2'b00;
      treble_applied <= 16'h0000;
      bass_applied   <= 16'h0000;
      treble_gain    <= `REG_RESET_VALUE;
      bass_gain      <= `REG_RESET_VALUE;
      headroom       <= `REG_RESET_VALUE;
      anc_ready      <= 1'b0;
      anc_count      <= 16'h0000;
    end else begin
      state          <= next_state;
      treble_low     <= next_treble_low;
      treble_high    <= next_treble_high;
      bass_low       <= next_bass_low;
      bass_high      <= next_bass_high;
      treble_written <= next_treble_written;
      bass_written   <= next_bass_written;
      treble_applied <= next_treble_applied;
      bass_applied   <= next_bass_applied;
      treble_gain    <= next_treble_gain;
      bass_gain      <= next_bass_gain;
      headroom       <= next_headroom;
      anc_ready      <= next_anc_ready;
      anc_count      <= next_anc_count;
    end
  end

  // ****************************************
  // ancillary byte buffer
  // ****************************************

  // core loads bytes; both resets zero the whole buffer
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int i = 0; i < ANC_BYTES; i++) begin
        anc_mem[i] <= `REG_RESET_VALUE;
      end
    end else if (clear_all) begin
      for (int i = 0; i < ANC_BYTES; i++) begin
        anc_mem[i] <= `REG_RESET_VALUE;
      end
    end else if (anc_load_in && (int'(anc_load_index_in) < ANC_BYTES)) begin
      anc_mem[anc_load_index_in] <= anc_load_data_in;
    end
  end

  // ****************************************
  // read path
  // ****************************************

  // read data decode, unmapped offsets read zero
  always_comb begin
    next_rdata = rdata;
    if (reg_read_in) begin
      if (reg_addr_in == `FIRMWARE_VERSION_OFS) begin
        next_rdata = boot_done_in ? FIRMWARE_CODE : 8'h00;
      end else if (reg_addr_in == `DECODE_RUN_CONTROL_OFS) begin
        next_rdata = {7'h00, state == tone_anc_pkg::DECODE_RUNNING};
      end else if (reg_addr_in == `TREBLE_CORNER_LOW_OFS) begin
        next_rdata = treble_low;
      end else if (reg_addr_in == `TREBLE_CORNER_HIGH_OFS) begin
        next_rdata = treble_high;
      end else if (reg_addr_in == `BASS_CORNER_LOW_OFS) begin
        next_rdata = bass_low;
      end else if (reg_addr_in == `BASS_CORNER_HIGH_OFS) begin
        next_rdata = bass_high;
      end else if (reg_addr_in == `TREBLE_GAIN_OFS) begin
        next_rdata = treble_gain;
      end else if (reg_addr_in == `BASS_GAIN_OFS) begin
        next_rdata = bass_gain;
      end else if (reg_addr_in == `TONE_HEADROOM_OFS) begin
        next_rdata = headroom;
      end else if ((reg_addr_in >= `ANC_BUFFER_FIRST_OFS) &&
                   (reg_addr_in <= `ANC_BUFFER_LAST_OFS)) begin
        next_rdata = anc_mem[6'(reg_addr_in - `ANC_BUFFER_FIRST_OFS)];
      end else if (reg_addr_in == `ANC_READY_STATUS_OFS) begin
        next_rdata = {7'h00, anc_ready};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // read data register
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // outputs toward host and decoder core
  assign reg_rdata_out                = rdata;
  assign decode_run_out               = (state == tone_anc_pkg::DECODE_RUNNING);
  assign treble_corner_value_out      = treble_applied;
  assign bass_corner_value_out        = bass_applied;
  assign treble_gain_out              = treble_gain;
  assign bass_gain_out                = bass_gain;
  assign tone_headroom_out            = headroom;
  assign ancillary_bit_count_low_out  = anc_count[7:0];
  assign ancillary_bit_count_high_out = anc_count[15:8];

endmodule

// file: decoder_tone_ancillary_regs_checker.sv
// assertion checker for the tone and ancillary register bank
module decoder_tone_ancillary_regs_checker #(
  parameter logic [7:0] FIRMWARE_CODE = 8'h5a
) (
  input wire logic               clk_in,
  input wire logic               nrst_in,
  input wire logic               soft_reset_in,
  input wire logic               boot_done_in,
  input wire logic               reg_write_in,
  input wire logic               reg_read_in,
  input wire logic [7:0]         reg_addr_in,
  input wire logic [7:0]         reg_wdata_in,
  input wire logic [7:0]         reg_rdata_out,
  input wire logic               anc_block_done_in,
  input wire logic [15:0]        anc_bit_count_in,
  input wire logic               decode_run_out,
  input wire logic [15:0]        treble_corner_value_out,
  input wire logic [15:0]        bass_corner_value_out,
  input wire logic signed [7:0]  treble_gain_out,
  input wire logic [7:0]         tone_headroom_out,
  input wire logic [7:0]         ancillary_bit_count_low_out,
  input wire logic [7:0]         ancillary_bit_count_high_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // a write that no soft reset overrides
  wire logic wr_ok = reg_write_in && !soft_reset_in;
  sequence s_wr(logic [7:0] a); wr_ok && reg_addr_in == a; endsequence
  property p_run; s_wr(8'h72) ##0 reg_wdata_in[0] |=> decode_run_out; endproperty
  a_run: assert property (p_run) else $error("run flag not set");
  property p_tgain; s_wr(8'h7b) |=> treble_gain_out == $past(reg_wdata_in); endproperty
  a_tgain: assert property (p_tgain) else $error("treble gain wrong");
  property p_head; s_wr(8'h7d) |=> tone_headroom_out == $past(reg_wdata_in); endproperty
  a_head: assert property (p_head) else $error("headroom wrong");
  property p_treble; s_wr(8'h77) ##1 s_wr(8'h78) |=>
    treble_corner_value_out == {$past(reg_wdata_in), $past(reg_wdata_in, 2)}; endproperty
  a_treble: assert property (p_treble) else $error("treble corner wrong");
  property p_bass; s_wr(8'h79) ##1 s_wr(8'h7a) |=>
    bass_corner_value_out == {$past(reg_wdata_in), $past(reg_wdata_in, 2)}; endproperty
  a_bass: assert property (p_bass) else $error("bass corner wrong");
  property p_soft; soft_reset_in |=> !(|{decode_run_out, treble_corner_value_out,
    bass_corner_value_out, tone_headroom_out, ancillary_bit_count_low_out}); endproperty
  a_soft: assert property (p_soft) else $error("soft reset left a value");
  property p_count; anc_block_done_in && !soft_reset_in |=> {ancillary_bit_count_high_out,
    ancillary_bit_count_low_out} == $past(anc_bit_count_in); endproperty
  a_count: assert property (p_count) else $error("bit count not latched");
  property p_version; reg_read_in && reg_addr_in == 8'h71 |=>
    reg_rdata_out == ($past(boot_done_in) ? FIRMWARE_CODE : 8'h00); endproperty
  a_version: assert property (p_version) else $error("version readout wrong");
endmodule

bind decoder_tone_ancillary_regs decoder_tone_ancillary_regs_checker #(
  .FIRMWARE_CODE(FIRMWARE_CODE)) checker_inst (.clk_in, .nrst_in, .soft_reset_in,
  .boot_done_in, .reg_write_in, .reg_read_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .anc_block_done_in, .anc_bit_count_in, .decode_run_out, .treble_corner_value_out,
  .bass_corner_value_out, .treble_gain_out, .tone_headroom_out,
  .ancillary_bit_count_low_out, .ancillary_bit_count_high_out);

// file: decoder_tone_ancillary_regs_test.sv
// self-checking bench for the tone and ancillary register bank
module decoder_tone_ancillary_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FW = 8'h3c; // arbitrary version code
  logic clk_in = 1'b0, nrst_in = 1'b0, soft_reset_in = 1'b0, boot_done_in = 1'b0;
  logic reg_write_in = 1'b0, reg_read_in = 1'b0, go = 1'b0, ld, dn, run;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, hr, cl, ch, dat;
  logic signed [7:0] tg, bg;
  logic [15:0] tc, bc, cnt;
  logic [5:0] idx;
  int errors = 0, n_compared = 0;
  always #20 clk_in = ~clk_in;
  decoder_tone_ancillary_regs #(.FIRMWARE_CODE(FW)) decoder_tone_ancillary_regs_inst (
    .clk_in, .nrst_in, .soft_reset_in, .boot_done_in, .reg_write_in, .reg_read_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .anc_load_in(ld), .anc_load_index_in(idx),
    .anc_load_data_in(dat), .anc_block_done_in(dn), .anc_bit_count_in(cnt),
    .decode_run_out(run), .treble_corner_value_out(tc), .bass_corner_value_out(bc),
    .treble_gain_out(tg), .bass_gain_out(bg), .tone_headroom_out(hr),
    .ancillary_bit_count_low_out(cl), .ancillary_bit_count_high_out(ch));
  anc_source #(.GAP(1)) anc_source_inst (.clk_in, .go_in(go), .load_out(ld),
    .index_out(idx), .data_out(dat), .done_out(dn), .count_out(cnt));
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_in);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_in);
    reg_write_in = 1'b0;
    reg_read_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_in);
    reg_read_in = 1'b0;
    @(negedge clk_in);
    chk($sformatf("reg %h", a), {8'h00, reg_rdata_out}, {8'h00, exp});
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    for (int a = 8'h72; a <= 8'h7e; a++) rd(8'(a), 8'h00);
    rd(8'hb6, 8'h00);
    rd(8'h71, 8'h00);
    boot_done_in = 1'b1;
    wr(8'h71, 8'hff);
    rd(8'h71, FW);
    $display("test reset_and_version done");
    // headroom first, then gains and corners, run last
    wr(8'h7d, 8'h0c);
    wr(8'h7b, 8'h0c);
    wr(8'h7c, 8'hf4);
    wr(8'h77, 8'hb8);
    wr(8'h78, 8'h0b);
    wr(8'h79, 8'hc8);
    wr(8'h7a, 8'h00);
    rd(8'h7c, 8'hf4);
    chk("headroom", {8'h00, hr}, 16'h000c);
    chk("treble gain", {8'h00, tg}, 16'h000c);
    chk("bass gain", {8'h00, bg}, 16'h00f4);
    chk("treble corner", tc, 16'h0bb8);
    chk("bass corner", bc, 16'h00c8);
    wr(8'h77, 8'h10);
    rd(8'h77, 8'h10);
    chk("half corner", tc, 16'h0bb8);
    wr(8'h78, 8'h0b);
    rd(8'h78, 8'h0b);
    chk("full corner", tc, 16'h0b10);
    chk("idle", {15'h0000, run}, 16'h0000);
    wr(8'h72, 8'h01);
    rd(8'h72, 8'h01);
    chk("run", {15'h0000, run}, 16'h0001);
    $display("test tone_and_run done");
    // one block from the core; done is sampled at the rising edge where it is settled
    go = 1'b1;
    for (int i = 0; i < 400 && dn !== 1'b1; i++) @(posedge clk_in);
    chk("block done", {15'h0000, dn}, 16'h0001);
    @(negedge clk_in);
    go = 1'b0;
    rd(8'hb6, 8'h01);
    for (int i = 0; i < 56; i++) rd(8'h7e + 8'(i), 8'(i) ^ 8'ha5);
    chk("bit count", {ch, cl}, 16'h01c0);
    wr(8'h7e, 8'h00);
    rd(8'h7e, 8'ha5);
    wr(8'hb6, 8'h01);
    rd(8'hb6, 8'h01);
    wr(8'hb6, 8'h00);
    rd(8'hb6, 8'h00);
    $display("test ancillary done");
    soft_reset_in = 1'b1;
    @(negedge clk_in);
    soft_reset_in = 1'b0;
    chk("run after soft reset", {15'h0000, run}, 16'h0000);
    chk("count after soft reset", {ch, cl}, 16'h0000);
    chk("treble after soft reset", tc, 16'h0000);
    chk("bass after soft reset", bc, 16'h0000);
    for (int a = 8'h72; a <= 8'h7e; a++) rd(8'(a), 8'h00);
    rd(8'hb6, 8'h00);
    $display("test soft_reset done");
    print_verdict();
  end
endmodule

// file: tone_anc_pkg.sv
// types shared by the tone and ancillary register bank
package tone_anc_pkg;
  // run state of the decoder core
  typedef enum logic [1:0] {
    DECODE_IDLE    = 2'b01,
    DECODE_RUNNING = 2'b10
  } decode_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// file: tone_anc_regs.svh
// register offsets, reset values and field positions of the tone and ancillary register bank
`ifndef TONE_ANC_REGS_SVH
`define TONE_ANC_REGS_SVH
`define FIRMWARE_VERSION_OFS      8'h71
`define DECODE_RUN_CONTROL_OFS    8'h72
`define TREBLE_CORNER_LOW_OFS     8'h77
`define TREBLE_CORNER_HIGH_OFS    8'h78
`define BASS_CORNER_LOW_OFS       8'h79
`define BASS_CORNER_HIGH_OFS      8'h7a
`define TREBLE_GAIN_OFS           8'h7b
`define BASS_GAIN_OFS             8'h7c
`define TONE_HEADROOM_OFS         8'h7d
`define ANC_BUFFER_FIRST_OFS      8'h7e
`define ANC_BUFFER_LAST_OFS       8'hb5
`define ANC_READY_STATUS_OFS      8'hb6
`define ANC_BUFFER_BYTES          56
`define REG_RESET_VALUE           8'h00
`define RUN_BIT                   0
`define ANC_READY_BIT             0
`endif
